// file: design/nva_pkg.sv
// constants, field layout and types of the non-volatile data memory access block
// assumes a cpu core that owns the special register bus and the interrupt controller
package nva_pkg;
   localparam int          NV_DEPTH        = 128;
   localparam int          NV_AW           = 7;
   // sector 0 offsets of the direct registers
   localparam logic [7:0]  OFS_IND_ONE     = 8'h02;
   localparam logic [7:0]  OFS_PTR_LO      = 8'h03;
   localparam logic [7:0]  OFS_PTR_HI      = 8'h04;
   localparam logic [7:0]  OFS_LOCATION    = 8'h2C;
   localparam logic [7:0]  OFS_BYTE        = 8'h2D;
   // sector 1 location of the control register
   localparam logic [7:0]  OFS_CONTROL     = 8'h40;
   localparam logic [7:0]  SECTOR0         = 8'h00;
   localparam logic [7:0]  SECTOR1         = 8'h01;
   // control bit positions
   localparam int          BIT_PROG_PERMIT = 3;
   localparam int          BIT_PROG_TRIG   = 2;
   localparam int          BIT_FETCH_PERM  = 1;
   localparam int          BIT_FETCH_TRIG  = 0;
   // reset values
   localparam logic [7:0]  RST_LOCATION    = 8'h00;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [7:0]  RST_POINTER     = 8'h00;
   // timing at the 10 MHz reference clock
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          READ_TIME_NS    = 200;
   localparam int          WRITE_TIME_US   = 2000;
   localparam int          READ_CYCLES     = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WRITE_CYCLES    = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W           = 16;

   typedef enum logic [1:0] {
      NVA_IDLE  = 2'b00,
      NVA_READ  = 2'b01,
      NVA_WRITE = 2'b10
   } nva_state_e;
endpackage

// file: design/nva_mem_if.sv
// carrier between the register front end and the storage core
// assumes both ends sit on the same reference clock
`timescale 1ns/100ps
interface nva_mem_if;
   logic       start_rd;
   logic       start_wr;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic       done_rd;
   logic       done_wr;
   logic [7:0] rdata;
   modport ctrl  (output start_rd, output start_wr, output addr, output wdata,
                  input done_rd, input done_wr, input rdata);
   modport store (input start_rd, input start_wr, input addr, input wdata,
                  output done_rd, output done_wr, output rdata);
endinterface

// file: design/nva_core.sv
// storage array with its read and write cycle timer
// assumes a start pulse arrives only while the core is idle
`timescale 1ns/100ps
module nva_core
   import nva_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
) (
   input  wire logic   ref_clk,
   input  wire logic   nrst,
   nva_mem_if.store    bus
);
   // array carries no reset: its content must survive a reset
   logic [7:0]         mem [NV_DEPTH];
   nva_state_e         state;
   nva_state_e         next_state;
   logic [CNT_W-1:0]   cnt;
   logic [CNT_W-1:0]   next_cnt;
   logic [NV_AW-1:0]   addr_l;
   logic [7:0]         data_l;
   wire                at_end = (cnt == '0);

   assign bus.done_rd = (state == NVA_READ) && at_end;
   assign bus.done_wr = (state == NVA_WRITE) && at_end;
   assign bus.rdata   = mem[addr_l];

   always_comb begin
      next_state = state;
      next_cnt   = at_end ? cnt : cnt - 1'b1;
      unique case (state)
         NVA_IDLE: begin
            if (bus.start_wr) begin
               next_state = NVA_WRITE;
               next_cnt   = CNT_W'(WRITE_CYC - 1);
            end else if (bus.start_rd) begin
               next_state = NVA_READ;
               next_cnt   = CNT_W'(READ_CYCLES - 1);
            end
         end
         NVA_READ:  if (at_end) next_state = NVA_IDLE;
         NVA_WRITE: if (at_end) next_state = NVA_IDLE;
         default:   next_state = NVA_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state <= NVA_IDLE;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         addr_l <= '0;
         data_l <= '0;
      end else if (state == NVA_IDLE && (bus.start_wr || bus.start_rd)) begin
         addr_l <= bus.addr;
         data_l <= bus.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (bus.done_wr) begin
         mem[addr_l] <= data_l;
      end
   end
endmodule

// file: design/nva_top.sv
// register front end of the non-volatile data memory: direct and indirect decode,
// control bits, completion flags and interrupt gating
// assumes one register access per cycle, issued by the cpu core synchronous to ref_clk
`timescale 1ns/100ps
module nva_top
   import nva_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_rvalid,
   input  wire logic       global_irq_enable,
   input  wire logic       nv_done_irq_enable,
   input  wire logic       mf_irq_enable,
   input  wire logic       stack_full,
   input  wire logic       irq_serviced,
   input  wire logic       nv_done_clear,
   output logic            nv_done_request,
   output logic            mf_request,
   output logic            irq_vector
);
   logic [7:0]  nv_location;
   logic [7:0]  nv_byte;
   logic [7:0]  pointer_one_low;
   logic [7:0]  pointer_one_high;
   logic        program_permit;
   logic        program_trigger;
   logic        fetch_permit;
   logic        fetch_trigger;

   nva_mem_if   mem_bus ();

   nva_core #(
      .WRITE_CYC (WRITE_CYC)
   ) u_core (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .bus       (mem_bus.store)
   );

   // the indirect port reaches whatever the pointer pair names
   wire         via_ptr   = (sfr_addr == OFS_IND_ONE);
   wire [7:0]   eff_hi    = via_ptr ? pointer_one_high : SECTOR0;
   wire [7:0]   eff_lo    = via_ptr ? pointer_one_low : sfr_addr;
   wire         in_s0     = (eff_hi == SECTOR0);
   wire         hit_loc   = in_s0 && (eff_lo == OFS_LOCATION);
   wire         hit_byte  = in_s0 && (eff_lo == OFS_BYTE);
   wire         hit_plo   = in_s0 && (eff_lo == OFS_PTR_LO);
   wire         hit_phi   = in_s0 && (eff_lo == OFS_PTR_HI);
   // control only at 40H of sector 1
   wire         hit_ctrl  = (eff_hi == SECTOR1) && (eff_lo == OFS_CONTROL);

   wire         wr_loc    = sfr_wr && hit_loc;
   wire         wr_byte   = sfr_wr && hit_byte;
   wire         wr_plo    = sfr_wr && hit_plo;
   wire         wr_phi    = sfr_wr && hit_phi;
   wire         wr_ctrl   = sfr_wr && hit_ctrl;

   wire         busy      = program_trigger || fetch_trigger;
   wire         start_wr  = wr_ctrl && sfr_wdata[BIT_PROG_TRIG] && program_permit && !busy;
   wire         start_rd  = wr_ctrl && sfr_wdata[BIT_FETCH_TRIG] && fetch_permit && !busy && !start_wr;

   assign mem_bus.start_rd = start_rd;
   assign mem_bus.start_wr = start_wr;
   assign mem_bus.addr     = nv_location[NV_AW-1:0];
   assign mem_bus.wdata    = nv_byte;

   wire         rd_done   = mem_bus.done_rd;
   wire         wr_done   = mem_bus.done_wr;

   wire [7:0]   ctrl_view = {4'h0, program_permit, program_trigger, fetch_permit, fetch_trigger};
   wire [7:0]   rd_mux    = hit_loc  ? {1'b0, nv_location[6:0]} :
                            hit_byte ? nv_byte :
                            hit_plo  ? pointer_one_low :
                            hit_phi  ? pointer_one_high :
                            hit_ctrl ? ctrl_view : 8'h00;

   wire         next_vec  = mf_request && global_irq_enable && nv_done_irq_enable && mf_irq_enable && !stack_full;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         nv_location <= RST_LOCATION;
      end else if (wr_loc) begin
         nv_location <= {1'b0, sfr_wdata[6:0]};
      end
   end

   // byte only from software or read end
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         nv_byte <= RST_BYTE;
      end else if (rd_done) begin
         nv_byte <= mem_bus.rdata;
      end else if (wr_byte) begin
         nv_byte <= sfr_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pointer_one_low  <= RST_POINTER;
         pointer_one_high <= RST_POINTER;
      end else begin
         if (wr_plo) pointer_one_low <= sfr_wdata;
         if (wr_phi) pointer_one_high <= sfr_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         program_permit <= 1'b0;
         fetch_permit   <= 1'b0;
      end else if (wr_ctrl) begin
         program_permit <= sfr_wdata[BIT_PROG_PERMIT];
         fetch_permit   <= sfr_wdata[BIT_FETCH_PERM];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         program_trigger <= 1'b0;
         fetch_trigger   <= 1'b0;
      end else begin
         if (start_wr) program_trigger <= 1'b1;
         else if (wr_done) program_trigger <= 1'b0;
         if (start_rd) fetch_trigger <= 1'b1;
         else if (rd_done) fetch_trigger <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         nv_done_request <= 1'b0;
         mf_request      <= 1'b0;
         irq_vector      <= 1'b0;
      end else begin
         nv_done_request <= wr_done || (nv_done_request && !nv_done_clear);
         mf_request      <= wr_done || (mf_request && !irq_serviced);
         irq_vector      <= next_vec;
      end
   end

   // read answer one cycle after the request, zero when unmapped
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sfr_rdata  <= 8'h00;
         sfr_rvalid <= 1'b0;
      end else begin
         sfr_rdata  <= sfr_rd ? rd_mux : 8'h00;
         sfr_rvalid <= sfr_rd;
      end
   end

   // helper logic that only the checks below read
   logic [31:0] hold_cnt;
   logic        last_rd_loc;
   logic        last_rd_ctrl;
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hold_cnt     <= '0;
         last_rd_loc  <= 1'b0;
         last_rd_ctrl <= 1'b0;
      end else begin
         hold_cnt     <= program_trigger ? hold_cnt + 1 : '0;
         last_rd_loc  <= sfr_rd && hit_loc;
         last_rd_ctrl <= sfr_rd && hit_ctrl;
      end
   end

   a_prog_needs_permit: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(program_trigger) |-> $past(program_permit))
      else $error("write cycle started without prior permit");

   a_fetch_needs_permit: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(fetch_trigger) |-> $past(fetch_permit))
      else $error("read cycle started without prior permit");

   a_no_permit_no_write: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!program_permit && !program_trigger) |=> !program_trigger)
      else $error("write began while permit was clear");

   a_write_length: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(program_trigger) |-> (hold_cnt == WRITE_CYC))
      else $error("write cycle length differs from timer value");

   a_done_flags_set: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(program_trigger) |-> (nv_done_request && mf_request))
      else $error("write end did not raise both request flags");

   a_service_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      (irq_serviced && !wr_done && !nv_done_clear && nv_done_request) |=> (!mf_request && nv_done_request))
      else $error("service must clear only the multi-function flag");

   a_vector_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
      irq_vector |-> $past(global_irq_enable && nv_done_irq_enable && mf_irq_enable && !stack_full))
      else $error("vector raised while an enable was off or stack full");

   a_byte_held: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!$past(rd_done) && !$past(wr_byte)) |-> $stable(nv_byte))
      else $error("data byte changed without an operation");

   a_read_result: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(fetch_trigger) |-> (nv_byte == $past(mem_bus.rdata)))
      else $error("read end did not deliver the stored byte");

   a_location_top: assert property (@(posedge ref_clk) disable iff (!nrst)
      last_rd_loc |-> (sfr_rvalid && !sfr_rdata[7]))
      else $error("location top bit read back as one");

   a_ctrl_upper: assert property (@(posedge ref_clk) disable iff (!nrst)
      last_rd_ctrl |-> (sfr_rdata[7:4] == 4'h0))
      else $error("upper control bits read back nonzero");

   a_reset_guard: assert property (@(posedge ref_clk)
      !nrst |=> (!program_permit && pointer_one_high == 8'h00))
      else $error("reset left permit or pointer high set");

   a_no_permit_no_read: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!fetch_permit && !fetch_trigger) |=> !fetch_trigger)
      else $error("read began while permit was clear");

   a_read_length: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(fetch_trigger) |=> fetch_trigger ##1 !fetch_trigger)
      else $error("read cycle length differs from two cycles");

   a_write_end_timed: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(program_trigger) |-> $past(wr_done))
      else $error("write trigger cleared before the timer ran out");

   a_read_end_timed: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(fetch_trigger) |-> $past(rd_done))
      else $error("read trigger cleared before the byte was delivered");

   a_one_cycle_kind: assert property (@(posedge ref_clk) disable iff (!nrst)
      !(program_trigger && fetch_trigger))
      else $error("read and write cycles running together");

   // the next four checks reach into the storage core for its latches and array
   a_latch_write: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(program_trigger) |->
         (u_core.addr_l == $past(nv_location[NV_AW-1:0]) && u_core.data_l == $past(nv_byte)))
      else $error("write cycle did not latch location and byte");

   a_latch_read: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(fetch_trigger) |-> (u_core.addr_l == $past(nv_location[NV_AW-1:0])))
      else $error("read cycle did not latch the location");

   a_latch_held: assert property (@(posedge ref_clk) disable iff (!nrst)
      (busy && $past(busy)) |-> ($stable(u_core.addr_l) && $stable(u_core.data_l)))
      else $error("latched location or byte moved during a cycle");

   a_store_written: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(program_trigger) |-> (u_core.mem[u_core.addr_l] == u_core.data_l))
      else $error("write end left the stored byte unchanged");

   a_answer_timing: assert property (@(posedge ref_clk) disable iff (!nrst)
      sfr_rvalid == ($past(sfr_rd) && $past(nrst)))
      else $error("read answer not exactly one cycle after the request");

   a_answer_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
      !sfr_rvalid |-> (sfr_rdata == 8'h00))
      else $error("read data not zero outside an answer");

   a_ctrl_reach: assert property (@(posedge ref_clk) disable iff (!nrst)
      ($changed(program_permit) || $changed(fetch_permit)) |->
         $past(sfr_wr && via_ptr && pointer_one_high == SECTOR1 && pointer_one_low == OFS_CONTROL))
      else $error("control bits changed without an access at 40H of sector 1");

   a_location_reach: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(nv_location) |-> $past(sfr_wr && (sfr_addr == OFS_LOCATION ||
         (via_ptr && pointer_one_high == SECTOR0 && pointer_one_low == OFS_LOCATION))))
      else $error("location changed without a sector 0 write");

   a_byte_reach: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(nv_byte) |-> $past(rd_done || (sfr_wr && (sfr_addr == OFS_BYTE ||
         (via_ptr && pointer_one_high == SECTOR0 && pointer_one_low == OFS_BYTE)))))
      else $error("data byte changed without a read end or sector 0 write");

   a_vector_raised: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mf_request && global_irq_enable && nv_done_irq_enable && mf_irq_enable && !stack_full) |=> irq_vector)
      else $error("vector missing although every enable was set");

   a_done_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
      (nv_done_request && !nv_done_clear) |=> nv_done_request)
      else $error("write-done flag dropped without a software clear");

   a_mf_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mf_request && !irq_serviced) |=> mf_request)
      else $error("multi-function flag dropped without service");

   a_flags_from_write: assert property (@(posedge ref_clk) disable iff (!nrst)
      ($rose(nv_done_request) || $rose(mf_request)) |-> $past(wr_done))
      else $error("request flag rose without a write end");
endmodule

// file: verification/nva_top_test.sv
// self-checking bench for the non-volatile data memory register front end
// assumes nva_top with a short write timer; the bench plays the cpu core on the register bus
`timescale 1ns/100ps
module nva_top_test;
   import nva_pkg::*;
   localparam int WCYC = 20;
   logic       ref_clk, nrst, sfr_wr, sfr_rd, sfr_rvalid;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic       gie, die, mie, stack_full, irq_serviced, nv_done_clear;
   logic       nv_done_request, mf_request, irq_vector;
   int         mismatches, n_compared;

   nva_top #(.WRITE_CYC(WCYC)) uut (
      .ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
      .global_irq_enable(gie), .nv_done_irq_enable(die), .mf_irq_enable(mie),
      .stack_full(stack_full), .irq_serviced(irq_serviced), .nv_done_clear(nv_done_clear),
      .nv_done_request(nv_done_request), .mf_request(mf_request), .irq_vector(irq_vector));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // strobes drop for one idle cycle so no signal changes twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(posedge ref_clk); #1;
      sfr_wr = 1'b0;
      @(posedge ref_clk); #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge ref_clk); #1;
      sfr_rd = 1'b0;
      chk("read valid", 8'h01, {7'h00, sfr_rvalid});
      v = sfr_rdata;
      @(posedge ref_clk); #1;
   endtask

   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(name, exp, v);
   endtask

   // poll a trigger bit through the indirect port until hardware clears it
   // gives up after maxn reads, whether or not the cycle has completed
   task automatic poll(input int b, input int maxn, output int n);
      logic [7:0] v;
      n = 0;
      do begin
         rd(OFS_IND_ONE, v);
         n++;
      end while (v[b] !== 1'b0 && n < maxn);
      chk("trigger cleared", 8'h00, {7'h00, v[b]});
   endtask

   task automatic t_regs;
      rchk("pointer high reset", OFS_PTR_HI, 8'h00);
      rchk("location reset", OFS_LOCATION, 8'h00);
      rchk("byte reset", OFS_BYTE, 8'h00);
      wr(OFS_LOCATION, 8'hFF);
      rchk("location top bit", OFS_LOCATION, 8'h7F);
      wr(OFS_PTR_LO, OFS_LOCATION);
      rchk("indirect sector 0", OFS_IND_ONE, 8'h7F);
      rchk("unmapped read", 8'hF0, 8'h00);
      wr(OFS_PTR_HI, SECTOR1);
      wr(OFS_PTR_LO, OFS_CONTROL);
      rchk("control reset", OFS_IND_ONE, 8'h00);
   endtask

   task automatic t_write;
      int n;
      wr(OFS_LOCATION, 8'h15);
      wr(OFS_BYTE, 8'hA5);
      wr(OFS_IND_ONE, 8'h04);
      rchk("trigger without permit", OFS_IND_ONE, 8'h00);
      // trigger right after permit, interrupts masked
      gie = 1'b0;
      wr(OFS_IND_ONE, 8'hF8);
      wr(OFS_IND_ONE, 8'h0C);
      gie = 1'b1;
      rchk("write started", OFS_IND_ONE, 8'h0C);
      wr(OFS_LOCATION, 8'h16);
      wr(OFS_BYTE, 8'h3C);
      chk("done early", 8'h00, {7'h00, nv_done_request});
      poll(BIT_PROG_TRIG, WCYC, n);
      chk("write lasted", 8'h01, {7'h00, n >= WCYC / 4 - 2});
      chk("done request", 8'h01, {7'h00, nv_done_request});
      chk("mf request", 8'h01, {7'h00, mf_request});
   endtask

   task automatic t_read;
      int n;
      wr(OFS_IND_ONE, 8'h01);
      rchk("fetch without permit", OFS_IND_ONE, 8'h00);
      wr(OFS_IND_ONE, 8'hF2);
      rchk("upper control bits", OFS_IND_ONE, 8'h02);
      wr(OFS_LOCATION, 8'h15);
      wr(OFS_IND_ONE, 8'h03);
      poll(BIT_FETCH_TRIG, 8, n);
      rchk("read data", OFS_BYTE, 8'hA5);
      repeat (5) @(posedge ref_clk);
      #1;
      rchk("read data held", OFS_BYTE, 8'hA5);
   endtask

   task automatic t_irq;
      gie = 1'b1;
      die = 1'b1;
      mie = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("vector enabled", 8'h01, {7'h00, irq_vector});
      stack_full = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("vector stack full", 8'h00, {7'h00, irq_vector});
      stack_full = 1'b0;
      die = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("vector masked", 8'h00, {7'h00, irq_vector});
      irq_serviced = 1'b1;
      @(posedge ref_clk); #1;
      irq_serviced = 1'b0;
      @(posedge ref_clk); #1;
      chk("mf cleared", 8'h00, {7'h00, mf_request});
      chk("done kept", 8'h01, {7'h00, nv_done_request});
      nv_done_clear = 1'b1;
      @(posedge ref_clk); #1;
      nv_done_clear = 1'b0;
      @(posedge ref_clk); #1;
      chk("done cleared", 8'h00, {7'h00, nv_done_request});
   endtask

   // mid-run reset clears permit and pointer, keeps stored bytes
   task automatic t_reset;
      int n;
      gie = 1'b0;
      wr(OFS_IND_ONE, 8'h08);
      wr(OFS_IND_ONE, 8'h0C);
      gie = 1'b1;
      poll(BIT_PROG_TRIG, WCYC, n);
      rchk("permit kept", OFS_IND_ONE, 8'h08);
      // two reset edges so the sampled history is clean at release
      nrst = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      rchk("pointer high after reset", OFS_PTR_HI, 8'h00);
      wr(OFS_PTR_HI, SECTOR1);
      wr(OFS_PTR_LO, OFS_CONTROL);
      rchk("permit after reset", OFS_IND_ONE, 8'h00);
      wr(OFS_IND_ONE, 8'h02);
      wr(OFS_LOCATION, 8'h15);
      wr(OFS_IND_ONE, 8'h03);
      poll(BIT_FETCH_TRIG, 8, n);
      rchk("byte kept over reset", OFS_BYTE, 8'hA5);
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      mismatches = 0;
      n_compared = 0;
      nrst = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      {gie, die, mie, stack_full, irq_serviced, nv_done_clear} = 6'h00;
      repeat (2) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      t_regs;
      t_write;
      t_read;
      t_irq;
      t_reset;
      stop_test;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #(3000 * 100);
      mismatches++;
      stop_test;
   end
endmodule
